/* hw/ict_pkg.sv */
// Constants and types for the instruction cycle sequencer
package ict_pkg;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [1:0]  SIZE_HALF   = 2'h1;
  localparam logic [1:0]  SIZE_WORD   = 2'h2;
  localparam logic [4:0]  MODE_UNDEF  = 5'h04;
  localparam logic [31:0] TRAP_VECTOR = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [31:0] HALF_BYTES  = 32'h0000_0002;

  // ****************************************
  // Timing and counts
  // ****************************************
  // Offer output, pin, two sync stages
  localparam logic [1:0]  SETTLE_CYC  = 2'h3;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [7:0]  CNT_TWO     = 8'h02;

  // ****************************************
  // Multiply early termination
  // ****************************************
  localparam int          MUL_B1      = 8;
  localparam int          MUL_B2      = 16;
  localparam int          MUL_B3      = 24;
  typedef logic [2:0] ict_m_t;
  localparam ict_m_t      M_ONE       = 3'h1;
  localparam ict_m_t      M_TWO       = 3'h2;
  localparam ict_m_t      M_THREE     = 3'h3;
  localparam ict_m_t      M_MAX       = 3'h4;

  typedef logic [7:0] ict_cnt_t;

  // ****************************************
  // Instruction classes
  // ****************************************
  typedef enum logic [4:0] {
    OP_DATA, OP_STATUS, OP_LOAD, OP_LOAD_MULT, OP_STORE,
    OP_STORE_MULT, OP_SWAP, OP_BRANCH, OP_SWI, OP_MUL, OP_MLA,
    OP_LONG_MULTIPLY_OP, OP_LONG_MULTIPLY_ACCUMULATE_OP, OP_CP_DATA, OP_CP_LOAD, OP_CP_STORE,
    OP_TO_CP, OP_FROM_CP, OP_UNDEF
  } ict_op_t;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OFFER = 3'h1,
    ST_EXEC  = 3'h3,
    ST_SKIP  = 3'h2,
    ST_TRAP1 = 3'h4,
    ST_TRAP2 = 3'h6,
    ST_VEC1  = 3'h7,
    ST_VEC2  = 3'h5
  } ict_state_t;

endpackage

/* hw/ict_mul_if.sv */
// Multiplier operand and early-termination term between modules
`timescale 1ns/1ps
`default_nettype none
interface ict_mul_if;
  logic [31:0]     operand;
  ict_pkg::ict_m_t m_term;
  modport calc (input operand, output m_term);
  modport user (output operand, input m_term);
endinterface
`default_nettype wire

/* hw/ict_mul_term.sv */
// Multiply cycle term from the multiplier operand
`timescale 1ns/1ps
`default_nettype none
module ict_mul_term
  import ict_pkg::*;
#(
  parameter int W = 32
)
(
  // Operand in, term out
  ict_mul_if.calc mif
);

  // ****************************************
  // Uniform upper bits
  // ****************************************
  logic [W-1-MUL_B1:0] hi1;
  logic [W-1-MUL_B2:0] hi2;
  logic [W-1-MUL_B3:0] hi3;
  logic                u1;
  logic                u2;
  logic                u3;

  assign hi1 = mif.operand[W-1:MUL_B1];
  assign hi2 = mif.operand[W-1:MUL_B2];
  assign hi3 = mif.operand[W-1:MUL_B3];
  assign u1  = (&hi1) || !(|hi1);
  assign u2  = (&hi2) || !(|hi2);
  assign u3  = (&hi3) || !(|hi3);

  // RULE12 early termination
  // RULE15 full length otherwise
  assign mif.m_term = u1 ? M_ONE : u2 ? M_TWO : u3 ? M_THREE : M_MAX;

endmodule
`default_nettype wire

/* hw/ict_seq.sv */
// Instruction cycle sequencer: bus cycles per class, skip, undefined trap
//
// Notes on behaviour
// RULE1 - Instruction nobody can execute, undefined included, takes the undefined trap.
// RULE2 - Trap: offer cycle, internal cycle, then two word fetches at vector; the code makes the second cycle a nonsequential fetch at pc+2L.
// RULE3 - Coprocessors hold both reply lines high through the trap.
// RULE4 - No coprocessor offer while in compressed 16-bit state.
// RULE5 - Failed condition: no execution, exactly one sequential cycle.
// RULE6 - Skip cycle is sequential opcode fetch at pc+2L; next is pc+3L.
// RULE7 - Three instructions overlap, so counts are incremental.
// RULE8 - Data op S; register shift +I; pc write +S+N; status S.
// RULE9 - Load S+N+I, multiple nS+N+I; pc load +S+N.
// RULE10 - Store 2N, multiple (n-1)S+2N, swap S+2N+I, branches 2S+N.
// RULE11 - Multiply S+mI, accumulate or long S+(m+1)I, long acc S+(m+2)I.
// RULE12 - m is 1, 2 or 3 by uniform upper multiplier bits.
// RULE13 - Coprocessor ops cost b busy cycles plus their fixed cycles.
// RULE14 - Trap fetches from fixed undefined vector, refilling the pipeline.
// RULE15 - Without early termination m is one above the largest case.
`timescale 1ns/1ps
`default_nettype none
module ict_seq
  import ict_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Instruction from decode
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire ict_op_t     instr_op,
  input  wire logic        instr_cond_pass,
  input  wire logic        instr_shift_reg,
  input  wire logic        instr_pc_write,
  input  wire logic [4:0]  instr_word_count,
  input  wire logic [31:0] instr_mul_operand,
  input  wire logic [31:0] instr_pc,
  // Core state
  input  wire logic        cur_compressed,
  input  wire logic        cur_translation,
  input  wire logic [4:0]  cur_mode,
  // Coprocessor replies, from pins
  input  wire logic        coproc_absent_resp,
  input  wire logic        coproc_busy_resp,
  // Memory bus
  output logic [31:0]      bus_addr,
  output logic [1:0]       access_size,
  output logic             write_not_read,
  output logic             memory_request_low,
  output logic             sequential_access,
  output logic             opcode_fetch_low,
  output logic             coproc_offer_low,
  output logic             translation_user_low,
  output logic [4:0]       mode_out,
  output logic             compressed_state_flag,
  // Status pulses
  output logic             instr_done,
  output logic             trap_taken,
  output logic             pipe_refill
);

  // ****************************************
  // Coprocessor reply synchronisers
  // ****************************************
  logic cpa_s1_q, cpa_s2_q, cpb_s1_q, cpb_s2_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cpa_s1_q <= 1'b1;
      cpa_s2_q <= 1'b1;
      cpb_s1_q <= 1'b1;
      cpb_s2_q <= 1'b1;
    end
    else
    begin
      cpa_s1_q <= coproc_absent_resp;
      cpa_s2_q <= cpa_s1_q;
      cpb_s1_q <= coproc_busy_resp;
      cpb_s2_q <= cpb_s1_q;
    end
  end

  // ****************************************
  // Accepted instruction
  // ****************************************
  ict_state_t  state_q, state_d, start_state;
  ict_op_t     op_q, sel_op;
  logic        shift_q, pcw_q, cmp_q, trans_q;
  logic [4:0]  wc_q, mode_q;
  logic [31:0] pc_q, pc_2l, pc_3l, step_l, next_addr_q;
  ict_m_t      m_q, sel_m;
  logic        accept, sel_shift, sel_pcw, is_cp_in, is_store_q;
  ict_cnt_t    sel_wc, sel_mc;

  ict_mul_if mif ();
  ict_mul_term #(.W(32)) u_mul_term (.mif(mif.calc));

  assign mif.operand = instr_mul_operand;
  assign accept      = instr_valid && instr_ready;
  assign sel_op      = accept ? instr_op : op_q;
  assign sel_shift   = accept ? instr_shift_reg : shift_q;
  assign sel_pcw     = accept ? instr_pc_write : pcw_q;
  assign sel_wc      = {3'h0, accept ? instr_word_count : wc_q};
  assign sel_m       = accept ? mif.m_term : m_q;
  assign sel_mc      = {5'h00, sel_m};
  assign is_cp_in    = instr_op inside {OP_CP_DATA, OP_CP_LOAD,
                       OP_CP_STORE, OP_TO_CP, OP_FROM_CP};
  assign is_store_q  = op_q inside {OP_STORE, OP_STORE_MULT, OP_SWAP,
                       OP_CP_STORE};
  assign step_l      = cmp_q ? HALF_BYTES : WORD_BYTES;
  assign pc_2l       = pc_q + step_l + step_l;
  assign pc_3l       = pc_2l + step_l;

  // RULE5 failed condition skips
  // RULE1 undefined goes to trap
  // RULE4 no offer in compressed state
  assign start_state = !instr_cond_pass ? ST_SKIP :
                       (instr_op == OP_UNDEF) ? ST_TRAP1 :
                       (is_cp_in && cur_compressed) ? ST_TRAP1 :
                       is_cp_in ? ST_OFFER : ST_EXEC;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      op_q    <= OP_DATA;
      shift_q <= 1'b0;
      pcw_q   <= 1'b0;
      wc_q    <= 5'h00;
      m_q     <= M_ONE;
      pc_q    <= 32'h0000_0000;
      cmp_q   <= 1'b0;
      trans_q <= 1'b0;
      mode_q  <= 5'h00;
    end
    else if (accept)
    begin
      op_q    <= instr_op;
      shift_q <= instr_shift_reg;
      pcw_q   <= instr_pc_write;
      wc_q    <= instr_word_count;
      m_q     <= mif.m_term;
      pc_q    <= instr_pc;
      cmp_q   <= cur_compressed;
      trans_q <= cur_translation;
      mode_q  <= cur_mode;
    end
  end

  // ****************************************
  // Cost per class
  // ****************************************
  ict_cnt_t cost_s, cost_n, cost_i, cost_c;

  always_comb
  begin
    cost_s = CNT_ZERO;
    cost_n = CNT_ZERO;
    cost_i = CNT_ZERO;
    cost_c = CNT_ZERO;
    case (sel_op)
      // RULE8 data and status costs
      OP_DATA:
      begin
        cost_s = sel_pcw ? CNT_TWO : CNT_ONE;
        cost_n = sel_pcw ? CNT_ONE : CNT_ZERO;
        cost_i = sel_shift ? CNT_ONE : CNT_ZERO;
      end
      OP_STATUS: cost_s = CNT_ONE;
      // RULE9 load costs
      OP_LOAD, OP_LOAD_MULT:
      begin
        cost_s = (sel_op == OP_LOAD) ? CNT_ONE : sel_wc;
        if (sel_pcw)
          cost_s = cost_s + CNT_ONE;
        cost_n = sel_pcw ? CNT_TWO : CNT_ONE;
        cost_i = CNT_ONE;
      end
      // RULE10 store, swap, branch costs
      OP_STORE: cost_n = CNT_TWO;
      OP_STORE_MULT, OP_CP_LOAD, OP_CP_STORE:
      begin
        cost_s = sel_wc - CNT_ONE;
        cost_n = CNT_TWO;
      end
      OP_SWAP:
      begin
        cost_s = CNT_ONE;
        cost_n = CNT_TWO;
        cost_i = CNT_ONE;
      end
      OP_BRANCH, OP_SWI:
      begin
        cost_s = CNT_TWO;
        cost_n = CNT_ONE;
      end
      // RULE11 multiply costs
      OP_MUL:
      begin
        cost_s = CNT_ONE;
        cost_i = sel_mc;
      end
      OP_MLA, OP_LONG_MULTIPLY_OP:
      begin
        cost_s = CNT_ONE;
        cost_i = sel_mc + CNT_ONE;
      end
      OP_LONG_MULTIPLY_ACCUMULATE_OP:
      begin
        cost_s = CNT_ONE;
        cost_i = sel_mc + CNT_TWO;
      end
      // RULE13 fixed part after busy-wait
      OP_CP_DATA: cost_s = CNT_ONE;
      OP_TO_CP:
      begin
        cost_n = CNT_ONE;
        cost_c = CNT_ONE;
      end
      OP_FROM_CP:
      begin
        cost_s = CNT_ONE;
        cost_i = CNT_ONE;
        cost_c = CNT_ONE;
      end
      default: cost_s = CNT_ONE;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  ict_cnt_t   s_left_q, n_left_q, i_left_q, c_left_q;
  ict_cnt_t   rem, exec_cnt_q, cost_tot_q;
  logic [1:0] settle_q;
  logic       exec_last, load_exec, ty_n, ty_s, ty_i;

  assign rem       = s_left_q + n_left_q + i_left_q + c_left_q;
  assign exec_last = (state_q == ST_EXEC) && (rem == CNT_ONE);
  assign ty_n      = n_left_q != CNT_ZERO;
  assign ty_s      = !ty_n && (s_left_q != CNT_ZERO);
  assign ty_i      = !ty_n && !ty_s && (i_left_q != CNT_ZERO);
  assign load_exec = (state_d == ST_EXEC) &&
                     ((state_q != ST_EXEC) || exec_last);

  // RULE7 next instruction taken on last cycle
  assign instr_ready = (state_q == ST_IDLE) || (state_q == ST_SKIP) ||
                       exec_last;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (accept) state_d = start_state;
      ST_SKIP:  state_d = accept ? start_state : ST_IDLE;
      ST_EXEC:
      begin
        if (exec_last)
          state_d = accept ? start_state : ST_IDLE;
      end
      // RULE13 busy-wait as internal cycles
      ST_OFFER:
      begin
        if (settle_q == 2'h0)
        begin
          if (cpa_s2_q)
            state_d = ST_TRAP2;
          else if (!cpb_s2_q)
            state_d = ST_EXEC;
        end
      end
      // RULE2 trap cycle order
      ST_TRAP1: state_d = ST_TRAP2;
      ST_TRAP2: state_d = ST_VEC1;
      ST_VEC1:  state_d = ST_VEC2;
      ST_VEC2:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || (state_d == ST_OFFER && state_q != ST_OFFER))
      settle_q <= SETTLE_CYC;
    else if (settle_q != 2'h0)
      settle_q <= settle_q - 2'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_left_q   <= CNT_ZERO;
      n_left_q   <= CNT_ZERO;
      i_left_q   <= CNT_ZERO;
      c_left_q   <= CNT_ZERO;
      exec_cnt_q <= CNT_ZERO;
      cost_tot_q <= CNT_ZERO;
    end
    else if (load_exec)
    begin
      s_left_q   <= cost_s;
      n_left_q   <= cost_n;
      i_left_q   <= cost_i;
      c_left_q   <= cost_c;
      exec_cnt_q <= CNT_ZERO;
      cost_tot_q <= cost_s + cost_n + cost_i + cost_c;
    end
    else if (state_q == ST_EXEC)
    begin
      exec_cnt_q <= exec_cnt_q + CNT_ONE;
      if (ty_n)
        n_left_q <= n_left_q - CNT_ONE;
      else if (ty_s)
        s_left_q <= s_left_q - CNT_ONE;
      else if (ty_i)
        i_left_q <= i_left_q - CNT_ONE;
      else if (c_left_q != CNT_ZERO)
        c_left_q <= c_left_q - CNT_ONE;
    end
  end

  // ****************************************
  // Bus cycle decode
  // ****************************************
  logic        st_exec, st_idle, in_vec, fetch_cyc;
  logic        o_mreq_low, o_seq, o_offer_low, o_write;
  logic [31:0] o_addr;

  assign st_exec   = state_q == ST_EXEC;
  assign st_idle   = state_q == ST_IDLE;
  assign in_vec    = (state_q == ST_VEC1) || (state_q == ST_VEC2);
  assign fetch_cyc = (state_q == ST_SKIP) || (state_q == ST_TRAP2) ||
                     in_vec;
  // RULE6 skip is a sequential fetch
  assign o_mreq_low = fetch_cyc ? 1'b0 : st_exec ? !(ty_n || ty_s) : 1'b1;
  assign o_seq      = (state_q == ST_SKIP) || in_vec ||
                      (st_exec && !ty_n && !ty_i);
  // RULE4 offer only outside compressed state
  assign o_offer_low = !((state_q == ST_OFFER) ||
                         ((state_q == ST_TRAP1) && !cmp_q));
  assign o_write    = st_exec && ty_n && is_store_q &&
                      (n_left_q == CNT_ONE);
  // RULE14 fixed vector fetches
  assign o_addr = (state_q == ST_VEC1) ? TRAP_VECTOR :
                  (state_q == ST_VEC2) ? TRAP_VECTOR + WORD_BYTES :
                  st_idle ? next_addr_q : pc_2l;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bus_addr              <= 32'h0000_0000;
      next_addr_q           <= 32'h0000_0000;
      access_size           <= SIZE_WORD;
      write_not_read        <= 1'b0;
      memory_request_low    <= 1'b1;
      sequential_access     <= 1'b0;
      opcode_fetch_low      <= 1'b1;
      coproc_offer_low      <= 1'b1;
      translation_user_low  <= 1'b0;
      mode_out              <= 5'h00;
      compressed_state_flag <= 1'b0;
      instr_done            <= 1'b0;
      trap_taken            <= 1'b0;
      pipe_refill           <= 1'b0;
    end
    else
    begin
      bus_addr              <= o_addr;
      access_size           <= (in_vec || !cmp_q) ? SIZE_WORD : SIZE_HALF;
      write_not_read        <= o_write;
      memory_request_low    <= o_mreq_low;
      sequential_access     <= o_seq;
      opcode_fetch_low      <= st_exec || st_idle;
      coproc_offer_low      <= o_offer_low;
      // RULE2 privileged undefined mode, compressed bit clear
      translation_user_low  <= in_vec ? 1'b1 : trans_q;
      mode_out              <= in_vec ? MODE_UNDEF : mode_q;
      compressed_state_flag <= in_vec ? 1'b0 : cmp_q;
      instr_done            <= exec_last || (state_q == ST_SKIP) ||
                               (state_q == ST_VEC2);
      trap_taken            <= state_q == ST_TRAP2;
      pipe_refill           <= state_q == ST_VEC1;
      // RULE6 next address after skip
      if ((state_q == ST_SKIP) || exec_last)
        next_addr_q <= pc_3l;
      else if (state_q == ST_VEC2)
        next_addr_q <= TRAP_VECTOR + WORD_BYTES + WORD_BYTES;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_trap_tail;
    state_q == ST_TRAP2 ##1 state_q == ST_VEC1 ##1 state_q == ST_VEC2;
  endsequence

  a_undef_enters_trap: assert property ( // RULE1
    accept && instr_cond_pass && instr_op == OP_UNDEF
    |=> state_q == ST_TRAP1) else $error("undefined op not trapped");
  a_trap_cycle_order: assert property ( // RULE2
    state_q == ST_TRAP1 |=> s_trap_tail) else $error("trap order wrong");
  a_vector_fetch: assert property ( // RULE14
    state_q == ST_VEC1 |=> bus_addr == TRAP_VECTOR &&
    mode_out == MODE_UNDEF && !compressed_state_flag &&
    translation_user_low && sequential_access)
    else $error("vector fetch signals wrong");
  a_no_offer_cmp: assert property ( // RULE4
    state_q == ST_TRAP1 && cmp_q |=> coproc_offer_low)
    else $error("offer made in compressed state");
  a_offer_not_cmp: assert property ( // RULE4
    state_q == ST_OFFER |-> !cmp_q) else $error("offer state compressed");
  a_skip_one_cycle: assert property ( // RULE5
    accept && !instr_cond_pass |=> state_q == ST_SKIP ##1 instr_done)
    else $error("skip not one cycle");
  a_skip_seq_fetch: assert property ( // RULE6
    state_q == ST_SKIP |=> !memory_request_low && sequential_access &&
    !opcode_fetch_low && bus_addr == $past(pc_2l))
    else $error("skip cycle not a sequential fetch");
  a_overlap_ready: assert property ( // RULE7
    exec_last |-> instr_ready) else $error("no overlap on last cycle");
  a_exec_length: assert property ( // RULE8
    exec_last |-> ict_cnt_t'(exec_cnt_q + CNT_ONE) == cost_tot_q)
    else $error("cycle count differs from cost");
  a_plain_data_op: assert property ( // RULE8
    accept && instr_cond_pass && instr_op == OP_DATA &&
    !instr_shift_reg && !instr_pc_write |=> exec_last)
    else $error("plain data op not one cycle");
  a_mul_cost: assert property ( // RULE11
    accept && instr_cond_pass && instr_op == OP_MUL
    |=> cost_tot_q == ict_cnt_t'({5'h00, $past(mif.m_term)} + CNT_ONE))
    else $error("multiply cost wrong");
  a_mul_term_max: assert property ( // RULE15
    !((&mif.operand[31:MUL_B3]) || !(|mif.operand[31:MUL_B3]))
    |-> mif.m_term == M_MAX) else $error("multiply term not maximal");
  a_mul_term_one: assert property ( // RULE12
    ((&mif.operand[31:MUL_B1]) || !(|mif.operand[31:MUL_B1]))
    |-> mif.m_term == M_ONE) else $error("early termination missed");

endmodule
`default_nettype wire

/* verif/ict_cop_model.sv */
// Coprocessor model answering the sequencer's offers
`timescale 1ns/1ps
`default_nettype none
module ict_cop_model
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Offer from the core
  input  wire logic       coproc_offer_low,
  // Bench controls
  input  wire logic       present,
  input  wire logic [3:0] busy_cycles,
  // Replies
  output logic            coproc_absent_resp,
  output logic            coproc_busy_resp
);
  logic [3:0] busy_q;
  logic       claim;

  // Busy countdown while the offer stands
  always_ff @(posedge clk_sys)
  begin
    if (srst || coproc_offer_low)
      busy_q <= busy_cycles;
    else if (busy_q != 4'h0)
      busy_q <= busy_q - 4'h1;
  end

  // Replies follow the offer pin within its cycle
  // lines high unless claimed
  assign claim              = present && !coproc_offer_low && !srst;
  assign coproc_absent_resp = !claim;
  assign coproc_busy_resp   = !claim || (busy_q != 4'h0);
endmodule
`default_nettype wire

/* verif/tb_instr_cycle_timing_undef_trap.sv */
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_instr_cycle_timing_undef_trap
  import ict_pkg::*;
;
  // ********
  // Signals
  // ********
  logic        clk_sys           = 1'b0;
  logic        srst              = 1'b1;
  logic        instr_valid       = 1'b0;
  ict_op_t     instr_op          = OP_DATA;
  logic        instr_cond_pass   = 1'b1;
  logic        instr_shift_reg   = 1'b0;
  logic        instr_pc_write    = 1'b0;
  logic [4:0]  instr_word_count  = 5'h01;
  logic [31:0] instr_mul_operand = 32'h0;
  logic [31:0] instr_pc          = 32'h0000_0100;
  logic        cur_compressed    = 1'b0;
  logic        cur_translation   = 1'b0;
  logic [4:0]  cur_mode          = 5'h10;
  logic        present           = 1'b1;
  logic [3:0]  busy_cycles       = 4'h6;
  logic [31:0] bus_addr;
  logic [1:0]  access_size;
  logic [4:0]  mode_out;
  logic        coproc_absent_resp, coproc_busy_resp, instr_ready;
  logic        write_not_read, memory_request_low, sequential_access;
  logic        opcode_fetch_low, coproc_offer_low, translation_user_low;
  logic        compressed_state_flag, instr_done, trap_taken, pipe_refill;
  logic        offer_seen, trap_seen, refill_seen;
  int          n_wr              = 0;
  int          n_errors          = 0;
  int          n_checks          = 0;

  always #2 clk_sys = ~clk_sys;

  ict_seq dut (.clk_sys, .srst, .instr_valid, .instr_ready, .instr_op,
    .instr_cond_pass, .instr_shift_reg, .instr_pc_write, .instr_word_count,
    .instr_mul_operand, .instr_pc, .cur_compressed, .cur_translation,
    .cur_mode, .coproc_absent_resp, .coproc_busy_resp, .bus_addr,
    .access_size, .write_not_read, .memory_request_low, .sequential_access,
    .opcode_fetch_low, .coproc_offer_low, .translation_user_low, .mode_out,
    .compressed_state_flag, .instr_done, .trap_taken, .pipe_refill);

  ict_cop_model cop (.clk_sys, .srst, .coproc_offer_low, .present,
    .busy_cycles, .coproc_absent_resp, .coproc_busy_resp);

  // ********
  // Tasks
  // ********
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Offer one instruction, return after the edge following its state edge, its first cycle on the outputs
  task automatic issue(input ict_op_t op);
    chk(instr_ready, 1'b1);
    instr_op = op;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    @(negedge clk_sys);
  endtask

  // Count bus cycle types {S,N,I,C} outside offer cycles
  task automatic run(input ict_op_t op, output logic [31:0] cnt);
    int k;
    cnt = 32'h0;
    offer_seen = 1'b0;
    trap_seen = 1'b0;
    refill_seen = 1'b0;
    n_wr = 0;
    issue(op);
    for (k = 0; k < 80; k++)
    begin
      offer_seen |= (coproc_offer_low === 1'b0);
      trap_seen |= (trap_taken === 1'b1);
      refill_seen |= (pipe_refill === 1'b1);
      if (write_not_read === 1'b1)
        n_wr++;
      if (coproc_offer_low === 1'b1)
        case ({memory_request_low, sequential_access})
          2'b01: cnt[31:24] += 8'h1;
          2'b00: cnt[23:16] += 8'h1;
          2'b10: cnt[15:8] += 8'h1;
          2'b11: cnt[7:0] += 8'h1;
          default: ;
        endcase
      if (instr_done === 1'b1)
        break;
      @(negedge clk_sys);
    end
    if (k == 80)
    begin
      n_errors++;
      $display("wrong value at %0t: no completion", $time);
      end_sim();
    end
  endtask

  task automatic cost(input ict_op_t op, input logic sh, input logic pw,
                      input logic [4:0] n, input logic [31:0] mul,
                      input logic [31:0] exp);
    logic [31:0] cnt;
    instr_shift_reg = sh;
    instr_pc_write = pw;
    instr_word_count = n;
    instr_mul_operand = mul;
    run(op, cnt);
    chk(cnt, exp);
    chk(n_wr, op inside {OP_STORE, OP_STORE_MULT, OP_SWAP, OP_CP_STORE});
    $display("test cost %s finished", op.name());
  endtask

  task automatic t_skip();
    logic [31:0] step;
    for (int c = 0; c < 2; c++)
    begin
      cur_compressed = c[0];
      step = c[0] ? HALF_BYTES : WORD_BYTES;
      instr_cond_pass = 1'b0;
      issue(OP_SWAP);
      chk({memory_request_low, sequential_access, opcode_fetch_low}, 32'h2);
      chk(bus_addr, instr_pc + 32'h2 * step);
      chk(instr_done, 1'b1);
      @(negedge clk_sys);
      chk({instr_done, memory_request_low}, 32'h1);
      chk(bus_addr, instr_pc + 32'h3 * step);
    end
    instr_cond_pass = 1'b1;
    cur_compressed = 1'b0;
    $display("test skip finished");
  endtask

  task automatic t_undef();
    present = 1'b0;
    issue(OP_UNDEF);
    chk({memory_request_low, sequential_access, coproc_offer_low}, 32'h4);
    chk({translation_user_low, mode_out}, {1'b0, cur_mode});
    chk(bus_addr, instr_pc + 32'h8);
    @(negedge clk_sys);
    chk({memory_request_low, sequential_access, coproc_offer_low}, 32'h1);
    chk(trap_taken, 1'b1);
    @(negedge clk_sys);
    chk(bus_addr, TRAP_VECTOR);
    chk({sequential_access, mode_out, compressed_state_flag}, {1'b1, MODE_UNDEF, 1'b0});
    chk({memory_request_low, translation_user_low, access_size}, {2'b01, SIZE_WORD});
    chk(pipe_refill, 1'b1);
    @(negedge clk_sys);
    chk(bus_addr, TRAP_VECTOR + WORD_BYTES);
    chk({memory_request_low, sequential_access, mode_out}, {2'b01, MODE_UNDEF});
    chk(instr_done, 1'b1);
    present = 1'b1;
    $display("test undefined finished");
  endtask

  task automatic t_trap(input ict_op_t op, input logic comp);
    logic [31:0] cnt;
    cur_compressed = comp;
    present = 1'b0;
    run(op, cnt);
    chk(offer_seen, !comp);
    chk({trap_seen, refill_seen}, 32'h3);
    present = 1'b1;
    cur_compressed = 1'b0;
    $display("test trap %s finished", op.name());
  endtask

  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    chk({memory_request_low, coproc_offer_low, access_size}, {2'b11, SIZE_WORD});
    t_skip();
    t_undef();
    t_trap(OP_CP_DATA, 1'b0);
    t_trap(OP_FROM_CP, 1'b1);
    t_trap(OP_UNDEF, 1'b1);
    cost(OP_DATA, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01000000);
    cost(OP_DATA, 1'b1, 1'b0, 5'd1, 32'h0, 32'h01000100);
    cost(OP_DATA, 1'b1, 1'b1, 5'd1, 32'h0, 32'h02010100);
    cost(OP_STATUS, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01000000);
    cost(OP_LOAD, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01010100);
    cost(OP_LOAD, 1'b0, 1'b1, 5'd1, 32'h0, 32'h02020100);
    cost(OP_LOAD_MULT, 1'b0, 1'b0, 5'd3, 32'h0, 32'h03010100);
    cost(OP_LOAD_MULT, 1'b0, 1'b1, 5'd16, 32'h0, 32'h11020100);
    cost(OP_STORE, 1'b0, 1'b0, 5'd1, 32'h0, 32'h00020000);
    cost(OP_STORE_MULT, 1'b0, 1'b0, 5'd1, 32'h0, 32'h00020000);
    cost(OP_STORE_MULT, 1'b0, 1'b0, 5'd4, 32'h0, 32'h03020000);
    cost(OP_SWAP, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01020100);
    cost(OP_BRANCH, 1'b0, 1'b0, 5'd1, 32'h0, 32'h02010000);
    cost(OP_SWI, 1'b0, 1'b0, 5'd1, 32'h0, 32'h02010000);
    cost(OP_MUL, 1'b0, 1'b0, 5'd1, 32'h0000_0012, 32'h01000100);
    cost(OP_MUL, 1'b0, 1'b0, 5'd1, 32'hffff_8000, 32'h01000200);
    cost(OP_MUL, 1'b0, 1'b0, 5'd1, 32'h0012_3456, 32'h01000300);
    cost(OP_MUL, 1'b0, 1'b0, 5'd1, 32'h1234_5678, 32'h01000400);
    cost(OP_MLA, 1'b0, 1'b0, 5'd1, 32'h0000_0012, 32'h01000200);
    cost(OP_LONG_MULTIPLY_OP, 1'b0, 1'b0, 5'd1, 32'h0012_3456, 32'h01000400);
    cost(OP_LONG_MULTIPLY_ACCUMULATE_OP, 1'b0, 1'b0, 5'd1, 32'h1234_5678, 32'h01000600);
    cost(OP_CP_DATA, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01000000);
    cost(OP_CP_LOAD, 1'b0, 1'b0, 5'd2, 32'h0, 32'h01020000);
    busy_cycles = 4'h0;
    cost(OP_CP_STORE, 1'b0, 1'b0, 5'd1, 32'h0, 32'h00020000);
    cost(OP_TO_CP, 1'b0, 1'b0, 5'd1, 32'h0, 32'h00010001);
    cost(OP_FROM_CP, 1'b0, 1'b0, 5'd1, 32'h0, 32'h01000101);
    end_sim();
  end
endmodule
`default_nettype wire
